// *** inc/dhbcc_pkg.sv ***
// Shared constants and types of the dual H-bridge chopper controller.
// Assumes a single 125 MHz clock; pin inputs pass the two-flop stage in the top.
package dhbcc_pkg;
  // Timing
  localparam int CLK_MHZ = 125;
  localparam int PWM_FREQ_KHZ = 50;
  localparam int PWM_CYCLES = CLK_MHZ * 1000 / PWM_FREQ_KHZ;
  localparam int PWM_CNT_W = 12;
  localparam int BLANK_NS = 3750;
  localparam int BLANK_CYCLES = (BLANK_NS * CLK_MHZ + 999) / 1000;
  localparam int BLANK_CNT_W = 9;
  localparam int MIXED_PCT = 75;
  localparam int MIXED_CYCLES = PWM_CYCLES * MIXED_PCT / 100;

  // Chopping comparator
  localparam int SENSE_GAIN = 5;
  localparam int PCT_FULL = 100;
  localparam int PCT_MID = 71;
  localparam int PCT_LOW = 38;
  localparam int PCT_W = 7;
  localparam int CODE_W = 10;
  localparam int PROD_W = 20;

  // Register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] CTRL_TIMEOUT_RST = 8'h40;
  localparam int ST_OCP_LSB = 0;
  localparam int ST_TSD = 2;
  localparam int ST_UV = 3;
  localparam int ST_FAULT = 4;
  localparam int ST_DECAY_LSB = 5;
  localparam int ST_RUN = 7;
  localparam int ST_PHASE_A_LSB = 8;
  localparam int ST_PHASE_B_LSB = 10;

  // Synchroniser width: all pin inputs
  localparam int SYNC_W = 18;

  // Decay pin code as presented by the three-level input stage
  localparam logic [1:0] DECAY_LOW = 2'h0;
  localparam logic [1:0] DECAY_HIGH = 2'h1;
  localparam logic [1:0] DECAY_OPEN = 2'h2;

  typedef enum logic [1:0] {DHBCC_BLANK, DHBCC_DRIVE, DHBCC_DECAY} dhbcc_phase_t;
endpackage

// *** verilog/dhbcc_sync.sv ***
// Two-flop synchroniser for a bundle of independent level inputs.
// Assumes each bit is a quasi-static level; no bus coherency across bits.
`timescale 1ns/1ns
module dhbcc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } dhbcc_sync_st_t;

  dhbcc_sync_st_t st_ff;
  dhbcc_sync_st_t nxt_st;

  always_comb begin
    nxt_st.meta = d;
    nxt_st.stable = st_ff.meta;
  end

  // Clears to zero, so undriven pins read low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0; // [RULE17]
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.stable;
endmodule

// *** verilog/dhbcc_chop.sv ***
// One H-bridge: input decode, chopping phases, decay selection and overcurrent latch.
// Assumes synchronised inputs and a shared period-start pulse from the top.
`timescale 1ns/1ns
module dhbcc_chop (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Sequencing from top
  input wire logic clr,
  input wire logic hold,
  input wire logic period_start,
  input wire logic past_mixed,
  // Control inputs
  input wire logic bridge_ctrl_a,
  input wire logic bridge_ctrl_b,
  input wire logic cur_sel_hi,
  input wire logic cur_sel_lo,
  input wire logic [1:0] decay_sel,
  // Sensing
  input wire logic [dhbcc_pkg::CODE_W-1:0] sense_node,
  input wire logic [dhbcc_pkg::CODE_W-1:0] bridge_reference,
  input wire logic near_zero,
  input wire logic overcurrent_guard,
  input wire logic overtemp_guard,
  input wire logic [7:0] ocp_timeout,
  // Drive and status
  output logic drv_a,
  output logic drv_a_oe,
  output logic drv_b,
  output logic drv_b_oe,
  output logic ocp_latched,
  output dhbcc_pkg::dhbcc_phase_t phase
);
  typedef struct packed {
    dhbcc_pkg::dhbcc_phase_t phase;
    logic [dhbcc_pkg::BLANK_CNT_W-1:0] blank_cnt;
    logic was_drive;
    logic zero_hit;
    logic [7:0] ocp_cnt;
    logic ocp_lat;
  } dhbcc_chop_st_t;

  dhbcc_chop_st_t st_ff;
  dhbcc_chop_st_t nxt_st;
  logic driving;
  logic disabled;
  logic trip;
  logic fast_now;
  logic [dhbcc_pkg::PCT_W-1:0] pct;
  logic [dhbcc_pkg::PROD_W-1:0] lhs;
  logic [dhbcc_pkg::PROD_W-1:0] rhs;

  always_comb begin
    driving = bridge_ctrl_a ^ bridge_ctrl_b;
    disabled = cur_sel_hi & cur_sel_lo; // [RULE7]
    case ({cur_sel_hi, cur_sel_lo}) // [RULE7]
      2'h0: pct = dhbcc_pkg::PCT_W'(dhbcc_pkg::PCT_FULL);
      2'h1: pct = dhbcc_pkg::PCT_W'(dhbcc_pkg::PCT_MID);
      2'h2: pct = dhbcc_pkg::PCT_W'(dhbcc_pkg::PCT_LOW);
      default: pct = '0;
    endcase
    // Sense scaled by gain and by 100 so the percentage needs no divider
    lhs = dhbcc_pkg::PROD_W'(sense_node)
        * dhbcc_pkg::PROD_W'(dhbcc_pkg::SENSE_GAIN * dhbcc_pkg::PCT_FULL); // [RULE6]
    rhs = dhbcc_pkg::PROD_W'(bridge_reference) * dhbcc_pkg::PROD_W'(pct); // [RULE6]
    trip = lhs >= rhs; // [RULE22]
  end

  always_comb begin
    nxt_st = st_ff;
    if (clr) begin
      nxt_st = '0; // [RULE13]
    end else if (hold) begin
      nxt_st.phase = dhbcc_pkg::DHBCC_BLANK; // [RULE14]
      nxt_st.blank_cnt = '0;
      nxt_st.was_drive = 1'b0;
      nxt_st.zero_hit = 1'b0;
      nxt_st.ocp_cnt = '0;
    end else begin
      nxt_st.was_drive = driving;
      // Own limit path, blind to sense, reference and current select
      if (overcurrent_guard) begin // [RULE19]
        if (st_ff.ocp_cnt >= ocp_timeout) begin
          nxt_st.ocp_lat = 1'b1; // [RULE18]
        end else begin
          nxt_st.ocp_cnt = st_ff.ocp_cnt + 8'h01;
        end
      end else begin
        nxt_st.ocp_cnt = '0;
      end
      case (st_ff.phase) // [RULE23]
        dhbcc_pkg::DHBCC_BLANK: begin
          if (st_ff.blank_cnt == dhbcc_pkg::BLANK_CNT_W'(dhbcc_pkg::BLANK_CYCLES - 1)) begin
            nxt_st.phase = dhbcc_pkg::DHBCC_DRIVE; // [RULE8]
          end else begin
            nxt_st.blank_cnt = st_ff.blank_cnt + 9'h001;
          end
        end
        dhbcc_pkg::DHBCC_DRIVE: begin
          if (driving && trip) begin
            nxt_st.phase = dhbcc_pkg::DHBCC_DECAY; // [RULE4]
            nxt_st.zero_hit = 1'b0;
          end
        end
        default: begin
          if (near_zero) begin
            nxt_st.zero_hit = 1'b1; // [RULE11]
          end
        end
      endcase
      // New period or fresh drive restarts blanking
      if (period_start || (driving && !st_ff.was_drive)) begin
        nxt_st.phase = dhbcc_pkg::DHBCC_BLANK; // [RULE4]
        nxt_st.blank_cnt = '0;
        nxt_st.zero_hit = 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_comb begin
    // Open pin counts as mixed
    fast_now = (decay_sel == dhbcc_pkg::DECAY_HIGH)
             || ((decay_sel != dhbcc_pkg::DECAY_LOW) && !past_mixed); // [RULE9] [RULE10]
    drv_a = bridge_ctrl_a; // [RULE1]
    drv_b = bridge_ctrl_b;
    drv_a_oe = bridge_ctrl_a | bridge_ctrl_b; // [RULE1] [RULE3]
    drv_b_oe = bridge_ctrl_a | bridge_ctrl_b;
    if (bridge_ctrl_a && bridge_ctrl_b) begin
      drv_a = 1'b0; // [RULE3]
      drv_b = 1'b0;
    end
    if (st_ff.phase == dhbcc_pkg::DHBCC_DECAY && driving) begin
      if (fast_now) begin
        drv_a = bridge_ctrl_b; // [RULE11]
        drv_b = bridge_ctrl_a;
        drv_a_oe = !st_ff.zero_hit;
        drv_b_oe = !st_ff.zero_hit;
      end else begin
        drv_a = 1'b0; // [RULE12]
        drv_b = 1'b0;
      end
    end
    if (disabled || st_ff.ocp_lat || overtemp_guard || clr || hold) begin
      drv_a_oe = 1'b0; // [RULE7] [RULE18] [RULE20]
      drv_b_oe = 1'b0;
    end
  end

  assign ocp_latched = st_ff.ocp_lat;
  assign phase = st_ff.phase;
endmodule

// *** verilog/dhbcc_top.sv ***
// Dual H-bridge chopper controller: pin sync, PWM period, AHB-Lite registers.
// Assumes analog front end supplies sense and reference codes on hclk,
// and a three-level stage presents the decay pin as a two-bit code.
//
// Notes on behaviour
// [RULE1] Pair 00 floats both outputs, 01 drives L/H, 10 H/L, 11 L/L.
// [RULE2] Controller PWMs one input, other low for fast, high for slow decay.
// [RULE3] Input off time: 00 floats all switches, 11 shorts the winding low.
// [RULE4] On trip the bridge stops driving until the next fixed period starts.
// [RULE5] Internal chopping period is 50 kHz, unrelated to input PWM.
// [RULE6] Trip when five times sense reaches the scaled bridge reference.
// [RULE7] Select 00 is 100%, 01 is 71%, 10 is 38%, 11 disables bridge.
// [RULE8] Comparator ignored 3.75 us after drive begins; also minimum on time.
// [RULE9] Decay pin low is slow, open is mixed, high is fast, both bridges.
// [RULE10] Mixed decay: fast until 75% of period, then slow.
// [RULE11] Fast decay reverses the bridge, floats it once current nears zero.
// [RULE12] Slow decay turns on both low-side switches.
// [RULE13] Reset input low resets logic, disables bridges, ignores inputs.
// [RULE14] Sleep low disables bridges, pump, regulator and clocks; ignores inputs.
// [RULE15] Controller waits about 1 ms after sleep release before relying on us.
// [RULE16] Controller must drive reset and sleep high to operate.
// [RULE17] Undriven control and current-select inputs read as low.
// [RULE18] Limit held past timeout disables bridge, pulls fault low, latched.
// [RULE19] Overcurrent path ignores sense, reference and current select.
// [RULE20] Over-temperature floats bridges and pulls fault; recovers by itself.
// [RULE21] Supply undervoltage disables everything and resets logic until recovery.
// [RULE22] Decay pin arrives as two-bit code; trip formed digitally per bridge.
// [RULE23] Each bridge sequences blank, drive, decay from the shared period.
`timescale 1ns/1ns
module dhbcc_top (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Global pins
  input wire logic reset_n_in,
  input wire logic sleep_n_in,
  input wire logic [1:0] decay_sel,
  // Bridge control pins, index 0 bridge A, index 1 bridge B
  input wire logic [1:0] bridge_ctrl_a,
  input wire logic [1:0] bridge_ctrl_b,
  input wire logic [1:0] cur_sel_hi,
  input wire logic [1:0] cur_sel_lo,
  // Analog indications
  input wire logic [dhbcc_pkg::CODE_W-1:0] sense_node_0,
  input wire logic [dhbcc_pkg::CODE_W-1:0] sense_node_1,
  input wire logic [dhbcc_pkg::CODE_W-1:0] bridge_reference_0,
  input wire logic [dhbcc_pkg::CODE_W-1:0] bridge_reference_1,
  input wire logic [1:0] near_zero,
  input wire logic [1:0] overcurrent_guard,
  input wire logic overtemp_guard,
  input wire logic undervoltage_guard,
  // Bridge outputs
  output logic [1:0] bridge_out_a,
  output logic [1:0] bridge_out_a_oe,
  output logic [1:0] bridge_out_b,
  output logic [1:0] bridge_out_b_oe,
  // Fault and supplies
  output logic fault_n_out,
  output logic fault_n_out_oe,
  output logic charge_pump_en,
  output logic ref_regulator_en
);
  typedef struct packed {
    logic [dhbcc_pkg::PWM_CNT_W-1:0] pwm_cnt;
    logic period_start;
    logic dp_wr;
    logic [dhbcc_pkg::ADDR_W-1:0] dp_addr;
    logic [7:0] ocp_timeout;
    logic [31:0] rdata;
    logic readyout;
    logic [1:0] out_a;
    logic [1:0] out_a_oe;
    logic [1:0] out_b;
    logic [1:0] out_b_oe;
    logic fault_oe;
    logic pump_en;
    logic reg_en;
  } dhbcc_top_st_t;

  dhbcc_top_st_t st_ff;
  dhbcc_top_st_t nxt_st;

  logic [dhbcc_pkg::SYNC_W-1:0] pins_raw;
  logic [dhbcc_pkg::SYNC_W-1:0] pins_s;
  logic rst_s;
  logic sleep_s;
  logic [1:0] decay_s;
  logic [1:0] ctrl_a_s;
  logic [1:0] ctrl_b_s;
  logic [1:0] sel_hi_s;
  logic [1:0] sel_lo_s;
  logic [1:0] zero_s;
  logic [1:0] ocp_s;
  logic tsd_s;
  logic uv_s;
  logic clr;
  logic hold;
  logic run;
  logic past_mixed;
  logic [1:0] drv_a;
  logic [1:0] drv_a_oe;
  logic [1:0] drv_b;
  logic [1:0] drv_b_oe;
  logic [1:0] ocp_lat;
  dhbcc_pkg::dhbcc_phase_t phase [2];
  logic [dhbcc_pkg::CODE_W-1:0] sense [2];
  logic [dhbcc_pkg::CODE_W-1:0] refv [2];
  logic [31:0] status;
  logic addr_ok;

  assign pins_raw = {reset_n_in, sleep_n_in, decay_sel, bridge_ctrl_a, bridge_ctrl_b,
                     cur_sel_hi, cur_sel_lo, near_zero, overcurrent_guard,
                     overtemp_guard, undervoltage_guard};

  dhbcc_sync #(
    .W(dhbcc_pkg::SYNC_W)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d(pins_raw),
    .q(pins_s)
  );

  assign {rst_s, sleep_s, decay_s, ctrl_a_s, ctrl_b_s, sel_hi_s, sel_lo_s,
          zero_s, ocp_s, tsd_s, uv_s} = pins_s;
  assign sense[0] = sense_node_0;
  assign sense[1] = sense_node_1;
  assign refv[0] = bridge_reference_0;
  assign refv[1] = bridge_reference_1;

  // Reset pin and undervoltage both wipe state; sleep only idles
  assign clr = !rst_s || uv_s; // [RULE13] [RULE21]
  assign hold = !sleep_s; // [RULE14]
  assign run = !clr && !hold;
  assign past_mixed = st_ff.pwm_cnt >= dhbcc_pkg::PWM_CNT_W'(dhbcc_pkg::MIXED_CYCLES); // [RULE10]

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_bridge
      dhbcc_chop u_chop (
        .hclk(hclk),
        .hresetn(hresetn),
        .clr(clr),
        .hold(hold),
        .period_start(st_ff.period_start),
        .past_mixed(past_mixed),
        .bridge_ctrl_a(ctrl_a_s[gi]),
        .bridge_ctrl_b(ctrl_b_s[gi]),
        .cur_sel_hi(sel_hi_s[gi]),
        .cur_sel_lo(sel_lo_s[gi]),
        .decay_sel(decay_s),
        .sense_node(sense[gi]),
        .bridge_reference(refv[gi]),
        .near_zero(zero_s[gi]),
        .overcurrent_guard(ocp_s[gi]),
        .overtemp_guard(tsd_s),
        .ocp_timeout(st_ff.ocp_timeout),
        .drv_a(drv_a[gi]),
        .drv_a_oe(drv_a_oe[gi]),
        .drv_b(drv_b[gi]),
        .drv_b_oe(drv_b_oe[gi]),
        .ocp_latched(ocp_lat[gi]),
        .phase(phase[gi])
      );
    end
  endgenerate

  always_comb begin
    status = '0;
    status[dhbcc_pkg::ST_OCP_LSB +: 2] = ocp_lat;
    status[dhbcc_pkg::ST_TSD] = tsd_s;
    status[dhbcc_pkg::ST_UV] = uv_s;
    status[dhbcc_pkg::ST_FAULT] = st_ff.fault_oe;
    status[dhbcc_pkg::ST_DECAY_LSB +: 2] = decay_s;
    status[dhbcc_pkg::ST_RUN] = run;
    status[dhbcc_pkg::ST_PHASE_A_LSB +: 2] = 2'(phase[0]);
    status[dhbcc_pkg::ST_PHASE_B_LSB +: 2] = 2'(phase[1]);
  end

  // Upper address bits must be zero for a hit
  assign addr_ok = haddr[31:dhbcc_pkg::ADDR_W] == '0;

  always_comb begin
    nxt_st = st_ff;
    // Period divider; held at zero while asleep, in reset or undervoltage
    nxt_st.period_start = 1'b0;
    if (!run) begin
      nxt_st.pwm_cnt = '0; // [RULE14]
    end else if (st_ff.pwm_cnt == dhbcc_pkg::PWM_CNT_W'(dhbcc_pkg::PWM_CYCLES - 1)) begin
      nxt_st.pwm_cnt = '0; // [RULE5]
      nxt_st.period_start = 1'b1;
    end else begin
      nxt_st.pwm_cnt = st_ff.pwm_cnt + 12'h001;
    end

    // AHB-Lite: zero wait states, always OKAY
    nxt_st.readyout = 1'b1;
    nxt_st.dp_wr = 1'b0;
    if (st_ff.dp_wr && st_ff.dp_addr == dhbcc_pkg::ADDR_CTRL) begin
      nxt_st.ocp_timeout = hwdata[7:0];
    end
    if (hsel && hready && htrans[1]) begin
      nxt_st.dp_wr = hwrite && addr_ok;
      nxt_st.dp_addr = haddr[dhbcc_pkg::ADDR_W-1:0];
      nxt_st.rdata = '0;
      if (!hwrite && addr_ok) begin
        if (haddr[7:0] == dhbcc_pkg::ADDR_CTRL) begin
          // Forward a write still in its data phase
          nxt_st.rdata[7:0] = nxt_st.ocp_timeout;
        end else if (haddr[7:0] == dhbcc_pkg::ADDR_STATUS) begin
          nxt_st.rdata = status;
        end
      end
    end

    // Registered pin drive
    nxt_st.out_a = drv_a;
    nxt_st.out_a_oe = drv_a_oe;
    nxt_st.out_b = drv_b;
    nxt_st.out_b_oe = drv_b_oe;
    nxt_st.fault_oe = (|ocp_lat) || tsd_s; // [RULE18] [RULE20]
    nxt_st.pump_en = sleep_s && !uv_s; // [RULE14] [RULE21]
    nxt_st.reg_en = sleep_s && !uv_s; // [RULE14]
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0;
      st_ff.ocp_timeout <= dhbcc_pkg::CTRL_TIMEOUT_RST;
      st_ff.readyout <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hreadyout = st_ff.readyout;
  assign hrdata = st_ff.rdata;
  assign hresp = 1'b0;
  assign bridge_out_a = st_ff.out_a;
  assign bridge_out_a_oe = st_ff.out_a_oe;
  assign bridge_out_b = st_ff.out_b;
  assign bridge_out_b_oe = st_ff.out_b_oe;
  // Open drain: only ever pulls low
  assign fault_n_out = 1'b0;
  assign fault_n_out_oe = st_ff.fault_oe;
  assign charge_pump_en = st_ff.pump_en;
  assign ref_regulator_en = st_ff.reg_en;

  // hsize unused: only whole-word transfers are supported
endmodule

// *** test/dhbcc_top_chk.sv ***
// Port checker of the bridge controller.
// Assumes three edges from a pin change to the bridge outputs.
`timescale 1ns/1ns
module dhbcc_top_chk (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Watched ports
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic reset_n_in,
  input wire logic sleep_n_in,
  input wire logic [1:0] bridge_ctrl_a,
  input wire logic [1:0] bridge_ctrl_b,
  input wire logic [1:0] cur_sel_hi,
  input wire logic [1:0] cur_sel_lo,
  input wire logic overtemp_guard,
  input wire logic undervoltage_guard,
  input wire logic [1:0] bridge_out_a_oe,
  input wire logic [1:0] bridge_out_b_oe,
  input wire logic fault_n_out,
  input wire logic fault_n_out_oe,
  input wire logic charge_pump_en
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic [1:0] on = bridge_out_a_oe | bridge_out_b_oe;
  a_bus_okay:
    assert property (hreadyout && !hresp) else $error("bus answer not ready okay");
  a_pair_float:
    assert property ((~($past(bridge_ctrl_a, 3) | $past(bridge_ctrl_b, 3)) & on) == 2'h0)
    else $error("bridge driven with pair 00");
  a_sel_off:
    assert property (($past(cur_sel_hi, 3) & $past(cur_sel_lo, 3) & on) == 2'h0)
    else $error("bridge driven with select 11");
  a_reset_off:
    assert property (!$past(reset_n_in, 3) |-> on == 2'h0) else $error("driven in reset");
  a_sleep_off:
    assert property (!$past(sleep_n_in, 3) |-> on == 2'h0 && !charge_pump_en)
    else $error("driven in sleep");
  a_uv_off:
    assert property ($past(undervoltage_guard, 3) |-> on == 2'h0 && !charge_pump_en)
    else $error("driven in undervoltage");
  a_temp_fault:
    assert property ($past(overtemp_guard, 3) |-> on == 2'h0 && fault_n_out_oe)
    else $error("over temperature not handled");
  a_fault_low:
    assert property (!fault_n_out) else $error("fault line drives high");
  c_fault: cover property ($rose(fault_n_out_oe));
  c_sleep: cover property (!$past(sleep_n_in, 3));
  c_drive: cover property ($rose(on[0]));
endmodule
bind dhbcc_top dhbcc_top_chk dhbcc_top_chk_inst (.hclk, .hresetn, .hreadyout, .hresp,
  .reset_n_in, .sleep_n_in, .bridge_ctrl_a, .bridge_ctrl_b, .cur_sel_hi, .cur_sel_lo,
  .overtemp_guard, .undervoltage_guard, .bridge_out_a_oe, .bridge_out_b_oe,
  .fault_n_out, .fault_n_out_oe, .charge_pump_en);

// *** test/dhbcc_ctl_model.sv ***
// Motor controller model driving the pin side of the bridge controller.
// Assumes one calling process; pins change just after hclk rises.
`timescale 1ns/1ns
module dhbcc_ctl_model #(
  parameter int WAKE_CYCLES = 16
) (
  // Clock
  hclk,
  // Pins
  reset_n_in,
  sleep_n_in,
  decay_sel,
  bridge_ctrl_a,
  bridge_ctrl_b,
  cur_sel_hi,
  cur_sel_lo
);
  input wire logic hclk;
  output logic reset_n_in;
  output logic sleep_n_in;
  output logic [1:0] decay_sel;
  output logic [1:0] bridge_ctrl_a;
  output logic [1:0] bridge_ctrl_b;
  output logic [1:0] cur_sel_hi;
  output logic [1:0] cur_sel_lo;
  // Released pins sit at their pull-down level, except the decay pin, which is left open
  initial begin
    reset_n_in = 1'b0;
    sleep_n_in = 1'b0;
    decay_sel = dhbcc_pkg::DECAY_OPEN;
    bridge_ctrl_a = 2'h0;
    bridge_ctrl_b = 2'h0;
    cur_sel_hi = 2'h0;
    cur_sel_lo = 2'h0;
  end
  // Speed is set by toggling one input against a held one
  task automatic pins(input logic [1:0] a, input logic [1:0] b);
    @(posedge hclk);
    bridge_ctrl_a <= a;
    bridge_ctrl_b <= b;
  endtask
  task automatic sel(input logic [1:0] hi, input logic [1:0] lo);
    @(posedge hclk);
    cur_sel_hi <= hi;
    cur_sel_lo <= lo;
  endtask
  // Wake wait shortened from about 1 ms to keep the run short
  task automatic mode(input logic rst, input logic slp, input logic [1:0] dec);
    logic woke;
    woke = slp && !sleep_n_in;
    @(posedge hclk);
    reset_n_in <= rst;
    sleep_n_in <= slp;
    decay_sel <= dec;
    if (woke) repeat (WAKE_CYCLES) @(posedge hclk);
  endtask
endmodule

// *** test/test_dual_hbridge_chopper_control.sv ***
// Self-checking bench of the bridge controller: registers, drive, chopping, guards.
// Assumes zero-wait AHB answers and a 2500-cycle chopping period.
`timescale 1ns/1ns
module test_dual_hbridge_chopper_control;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, overtemp_guard = 1'b0;
  logic undervoltage_guard = 1'b0, hready, hreadyout, hresp, fault_n_out, fault_n_out_oe;
  logic charge_pump_en, ref_regulator_en, reset_n_in, sleep_n_in;
  logic [1:0] htrans = 2'h0, near_zero = 2'h0, overcurrent_guard = 2'h0, decay_sel;
  logic [1:0] bridge_ctrl_a, bridge_ctrl_b, cur_sel_hi, cur_sel_lo;
  logic [1:0] bridge_out_a, bridge_out_a_oe, bridge_out_b, bridge_out_b_oe;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [9:0] sense_node_0 = 10'h0, sense_node_1, bridge_reference_0 = 10'd1000;
  logic [9:0] bridge_reference_1 = 10'd1000;
  int failures = 0, tests_run = 0, cyc = 0, n, t;
  int thr[3] = '{200, 142, 76};
  assign hready = hreadyout;
  assign sense_node_1 = sense_node_0;
  always #4 hclk = ~hclk;
  dhbcc_top dhbcc_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hreadyout, .hrdata, .hresp, .reset_n_in, .sleep_n_in, .decay_sel,
    .bridge_ctrl_a, .bridge_ctrl_b, .cur_sel_hi, .cur_sel_lo, .sense_node_0, .sense_node_1,
    .bridge_reference_0, .bridge_reference_1, .near_zero, .overcurrent_guard,
    .overtemp_guard, .undervoltage_guard, .bridge_out_a, .bridge_out_a_oe, .bridge_out_b,
    .bridge_out_b_oe, .fault_n_out, .fault_n_out_oe, .charge_pump_en, .ref_regulator_en);
  dhbcc_ctl_model dhbcc_ctl_model_inst (.hclk, .reset_n_in, .sleep_n_in, .decay_sel,
    .bridge_ctrl_a, .bridge_ctrl_b, .cur_sel_hi, .cur_sel_lo);
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Hang guard well above the expected run
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      summarize();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // Enable, then masked level, of both bridges: a_oe, b_oe, a, b
  function automatic logic [31:0] drv();
    return {24'h0, bridge_out_a_oe, bridge_out_b_oe, bridge_out_a & bridge_out_a_oe,
      bridge_out_b & bridge_out_b_oe};
  endfunction
  task automatic wait_st(input logic [31:0] e, input int mx);
    n = 0;
    @(negedge hclk);
    while (drv() !== e && n < mx) begin
      @(negedge hclk);
      n++;
    end
  endtask
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    dhbcc_ctl_model_inst.mode(1'b1, 1'b1, dhbcc_pkg::DECAY_HIGH);
    ahb(1'b0, {24'h0, dhbcc_pkg::ADDR_CTRL}, 32'h0);
    check(rd, {24'h0, dhbcc_pkg::CTRL_TIMEOUT_RST});
    ahb(1'b1, {24'h0, dhbcc_pkg::ADDR_CTRL}, 32'h10);
    ahb(1'b0, {24'h0, dhbcc_pkg::ADDR_CTRL}, 32'h0);
    check(rd, 32'h10);
    ahb(1'b1, 32'h08, 32'hFF);
    ahb(1'b0, 32'h08, 32'h0);
    check(rd, 32'h0);
    for (int i = 0; i < 4; i++) begin
      dhbcc_ctl_model_inst.pins({2{i[1]}}, {2{i[0]}});
      repeat (5) @(negedge hclk);
      check(drv(), i == 0 ? 32'h0 : i == 1 ? 32'hF3 : i == 2 ? 32'hFC : 32'hF0);
    end
    // Full-scale sense trips at the first chance
    @(posedge hclk);
    sense_node_0 <= 10'h3FF;
    dhbcc_ctl_model_inst.pins(2'h3, 2'h0);
    wait_st(32'hFC, 10);
    wait_st(32'hF3, 4000);
    check({31'h0, n >= dhbcc_pkg::BLANK_CYCLES - 1}, 32'h1);
    ahb(1'b0, {24'h0, dhbcc_pkg::ADDR_STATUS}, 32'h0);
    check(rd & 32'hF00, 32'hA00);
    @(posedge hclk);
    near_zero <= 2'h3;
    wait_st(32'h0, 10);
    check(drv(), 32'h0);
    wait_st(32'hFC, 3000);
    t = cyc;
    wait_st(32'h0, 3000);
    wait_st(32'hFC, 3000);
    check(cyc - t, dhbcc_pkg::PWM_CYCLES);
    @(posedge hclk);
    near_zero <= 2'h0;
    dhbcc_ctl_model_inst.mode(1'b1, 1'b1, dhbcc_pkg::DECAY_LOW);
    wait_st(32'hF0, 3000);
    check(drv(), 32'hF0);
    dhbcc_ctl_model_inst.mode(1'b1, 1'b1, dhbcc_pkg::DECAY_OPEN);
    wait_st(32'hFC, 3000);
    t = cyc;
    wait_st(32'hF3, 1000);
    check(drv(), 32'hF3);
    wait_st(32'hF0, 3000);
    check({31'h0, cyc - t >= 1873 && cyc - t <= 1877}, 32'h1);
    dhbcc_ctl_model_inst.mode(1'b1, 1'b1, dhbcc_pkg::DECAY_LOW);
    for (int k = 0; k < 3; k++) begin
      dhbcc_ctl_model_inst.sel({2{k[1]}}, {2{k[0]}});
      sense_node_0 <= 10'(thr[k] - 1);
      dhbcc_ctl_model_inst.pins(2'h0, 2'h0);
      dhbcc_ctl_model_inst.pins(2'h3, 2'h0);
      repeat (800) @(negedge hclk);
      check(drv(), 32'hFC);
      @(posedge hclk);
      sense_node_0 <= 10'(thr[k]);
      wait_st(32'hF0, 3000);
      check(drv(), 32'hF0);
    end
    dhbcc_ctl_model_inst.sel(2'h3, 2'h3);
    wait_st(32'h0, 8);
    check(drv(), 32'h0);
    dhbcc_ctl_model_inst.sel(2'h0, 2'h0);
    sense_node_0 <= 10'h0;
    overcurrent_guard <= 2'h2;
    repeat (12) @(posedge hclk);
    overcurrent_guard <= 2'h0;
    wait_st(32'h0, 8);
    check({31'h0, fault_n_out_oe}, 32'h0);
    @(posedge hclk);
    overcurrent_guard <= 2'h2;
    repeat (40) @(posedge hclk);
    overcurrent_guard <= 2'h0;
    // Bridge A may still sit in slow decay until the next period
    wait_st(32'h54, 3000);
    check(drv(), 32'h54);
    ahb(1'b0, {24'h0, dhbcc_pkg::ADDR_STATUS}, 32'h0);
    check(rd & 32'h3, 32'h2);
    dhbcc_ctl_model_inst.mode(1'b0, 1'b1, dhbcc_pkg::DECAY_LOW);
    repeat (5) @(posedge hclk);
    dhbcc_ctl_model_inst.mode(1'b1, 1'b1, dhbcc_pkg::DECAY_LOW);
    wait_st(32'hFC, 8);
    check({drv()[30:0], fault_n_out_oe}, {31'hFC, 1'b0});
    for (int k = 0; k < 3; k++) begin
      @(posedge hclk);
      if (k == 0) overtemp_guard <= 1'b1;
      if (k == 1) undervoltage_guard <= 1'b1;
      if (k == 2) dhbcc_ctl_model_inst.mode(1'b1, 1'b0, dhbcc_pkg::DECAY_LOW);
      wait_st(32'h0, 20);
      check({drv()[29:0], charge_pump_en, ref_regulator_en}, {30'h0, k == 0, k == 0});
      @(posedge hclk);
      overtemp_guard <= 1'b0;
      undervoltage_guard <= 1'b0;
      dhbcc_ctl_model_inst.mode(1'b1, 1'b1, dhbcc_pkg::DECAY_LOW);
      wait_st(32'hFC, 20);
      check(drv(), 32'hFC);
    end
    summarize();
  end
endmodule
